//--- dv/odp_key_model.sv
// Board model: keys, board pull-ups and the shared open-drain wires
`timescale 1ns/100ps
module odp_key_model (
    // Clock for the floating pattern
    input  wire logic        pclk,
    // Pin drivers: {two-bit, individual-bit, logic, wake}
    input  wire logic [13:0] oe,
    input  wire logic [13:0] pu,
    // Key closed pulls the pin to ground
    input  wire logic [13:0] key,
    // Resolved pin levels
    output logic      [13:0] lvl
);
    logic flip = 1'b0; // Stands in for a floating pin

    // An undriven pin must not read as a steady level, so it toggles
    always @(posedge pclk) begin
        flip <= ~flip;
    end

    // Any low driver wins, else a pull-up, else the wire floats
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            lvl[i] = (oe[i] | key[i]) ? 1'b0 : (pu[i] ? 1'b1 : flip);
        end
    end
endmodule

//--- dv/odp_port_top_tb.sv
// Self-checking bench for the open-drain port block
`timescale 1ns/100ps
`include "odp_map.svh"
module odp_port_top_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0473;
    logic        pready, pslverr, ext_int_req, backup_active, irq, o;
    logic        timer_underflow = 1'b0;
    logic [3:0]  wake_port_in, wake_port_out, wake_port_oe, wake_port_pullup_en, res;
    logic [3:0]  logic_port_in, logic_port_out, logic_port_oe;
    logic [3:0]  indiv_port_in, indiv_port_out, indiv_port_oe;
    logic [1:0]  single_pullup_en, two_bit_port_in, two_bit_port_out, two_bit_port_oe;
    logic [13:0] key = 14'h0, lvl;
    logic [33:0] e;              // {write, slverr, data} of a pending transfer
    logic [33:0] q_e[$];         // Expected answers in issue order
    int          n_fail = 0, tests_run = 0, n_ext = 0, m;

    always #20 pclk = ~pclk;     // 25 MHz

    odp_port_top u_odp_port_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .wake_port_in, .wake_port_out, .wake_port_oe,
        .wake_port_pullup_en, .logic_port_in, .logic_port_out, .logic_port_oe, .indiv_port_in,
        .indiv_port_out, .indiv_port_oe, .single_pullup_en, .two_bit_port_in, .two_bit_port_out,
        .two_bit_port_oe, .timer_underflow, .ext_int_req, .backup_active, .irq);

    // Ports without on-chip pull-ups get board resistors
    odp_key_model u_odp_key_model (.pclk(pclk), .key(key), .lvl(lvl),
        .oe({two_bit_port_oe, indiv_port_oe, logic_port_oe, wake_port_oe}),
        .pu({2'b11, single_pullup_en, 2'b11, 4'hF, wake_port_pullup_en}));
    assign {two_bit_port_in, indiv_port_in, logic_port_in, wake_port_in} = lvl;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        tests_run++;
        if (s !== ex) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, ex, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; for a read d is the expected data
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        q_e.push_back({w, err, d});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never drives psel twice in one step
        @(posedge pclk);
    endtask

    // Monitor: each completed transfer consumes the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = q_e.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!e[33]) chk("prdata", e[31:0], prdata);
        end
        if (ext_int_req === 1'b1) n_ext++;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog far beyond the expected run length
    initial begin
        #400000;
        n_fail++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `ODP_OFS_PULLUP, 32'h0);
        apb(0, `ODP_OFS_KWAKE, 32'h0);
        apb(0, `ODP_OFS_WAKE, 32'hF);
        chk("wake_oe", 32'h0, wake_port_oe);
        apb(1, `ODP_OFS_PULLUP, 32'h1);
        cyc(2);
        chk("wake_pu", 32'hF, wake_port_pullup_en);
        chk("single_pu", 32'h0, single_pullup_en);
        apb(1, `ODP_OFS_PULLUP, 32'h3);
        cyc(2);
        chk("single_pu", 32'h3, single_pullup_en);
        apb(0, 8'h40, 32'h0, 1'b1);                    // Unmapped read refused
        apb(1, 8'h44, 32'hFF, 1'b1);                   // Unmapped write refused
        // Random latch pattern: zeros pull pins low
        r = xs();
        apb(1, `ODP_OFS_WAKE, r & 32'hF);
        cyc(3);
        chk("wake_oe", ~r & 32'hF, wake_port_oe);
        chk("outs", 32'h0, {wake_port_out, logic_port_out, indiv_port_out, two_bit_port_out});
        apb(0, `ODP_OFS_PINS, 32'h3FF0 | (r & 32'hF));
        apb(1, `ODP_OFS_WAKE, 32'hF);
        apb(1, `ODP_OFS_TWOBIT, 32'h1);
        cyc(2);
        chk("two_bit_oe", 32'h2, two_bit_port_oe);
        apb(1, `ODP_OFS_TWOBIT, 32'h3);
        // Shared pins: port latch alone, then single latches selected
        apb(1, `ODP_OFS_INDIV, 32'hB);
        apb(1, `ODP_OFS_SINGLE, 32'h1);
        cyc(2);
        chk("indiv_oe", 32'h4, indiv_port_oe);
        apb(1, `ODP_OFS_ALTSEL, 32'hC);
        cyc(2);
        chk("indiv_oe", 32'hC, indiv_port_oe);
        apb(1, `ODP_OFS_INDIV, 32'hF);
        apb(1, `ODP_OFS_SINGLE, 32'h3);
        // Every logic operation against random key patterns
        for (int op = 0; op < 4; op++) begin
            r = xs();
            key[7:4] <= r[7:4];
            cyc(3);
            case (op)
                0: res = r[3:0] & ~r[7:4];
                1: res = r[3:0] | ~r[7:4];
                2: res = r[3:0] ^ ~r[7:4];
                default: res = ~r[7:4];
            endcase
            apb(1, `ODP_OFS_LOPREG, {26'h0, op[1:0], r[3:0]});
            apb(0, `ODP_OFS_LOPREG, {22'h0, op[1:0], r[3:0], res});
        end
        key[7:4] <= 4'h0;
        // Timer output toggles once per underflow
        apb(1, `ODP_OFS_ALTSEL, 32'h2);
        cyc(2);
        o = wake_port_oe[1];
        for (int i = 0; i < 2; i++) begin
            timer_underflow <= 1'b1;
            @(posedge pclk);
            timer_underflow <= 1'b0;
            cyc(3);
            chk("tout", {31'h0, o ^ !i[0]}, {31'h0, wake_port_oe[1]});
        end
        apb(0, `ODP_OFS_IRQSTS, 32'h4);
        // External interrupt on a falling edge, masked in
        apb(1, `ODP_OFS_ALTSEL, 32'h1);
        apb(1, `ODP_OFS_IRQMSK, 32'h1);
        cyc(2);
        m = n_ext;
        key[0] <= 1'b1;
        cyc(4);
        chk("ext_pulses", m + 1, n_ext);
        chk("irq", 32'h1, {31'h0, irq});
        apb(0, `ODP_OFS_IRQSTS, 32'h1);
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        key[0] <= 1'b0;
        // Back-up entry with an enabled key already held returns at once
        apb(1, `ODP_OFS_ALTSEL, 32'h0);
        apb(1, `ODP_OFS_KWAKE, 32'h2);
        key[2] <= 1'b1;
        cyc(2);
        apb(1, `ODP_OFS_BACKUP, 32'h1);
        cyc(3);
        chk("backup", 32'h0, {31'h0, backup_active});
        apb(0, `ODP_OFS_IRQSTS, 32'h2);
        // Wake pins disabled: stays in back-up until a logic key
        apb(1, `ODP_OFS_KWAKE, 32'h1);
        key[2] <= 1'b0;
        key[3] <= 1'b1;
        cyc(2);
        apb(1, `ODP_OFS_BACKUP, 32'h1);
        cyc(4);
        chk("backup", 32'h1, {31'h0, backup_active});
        key[4] <= 1'b1;
        cyc(4);
        chk("backup", 32'h0, {31'h0, backup_active});
        apb(0, `ODP_OFS_IRQSTS, 32'h2);
        key <= 14'h0;
        cyc(2);
        // Interrupt pin held low returns from back-up
        apb(1, `ODP_OFS_ALTSEL, 32'h1);
        apb(1, `ODP_OFS_BACKUP, 32'h1);
        cyc(3);
        chk("backup", 32'h1, {31'h0, backup_active});
        key[0] <= 1'b1;
        cyc(4);
        chk("backup", 32'h0, {31'h0, backup_active});
        key <= 14'h0;
        cyc(2);
        close_out();
    end
endmodule

//--- hw/odp_port_top.sv
// Open-drain port pins, pull-ups, key-on wakeup and shared pin functions
// Notes on behaviour
// - Pins pull low when latch zero; wake pin 1 follows the timer output instead when selected
// - Wake port pins: wakeup and pull-up switchable
// - Logic port wakes and feeds accumulator logic
// - Individual-bit port, bits two/three shared
// - Single-bit ports have switchable pull-ups
// - Timer output toggles once per underflow
// - Interrupt pin requests interrupt and wakes
// - Shared pins keep port I/O when alternate
// - Pull-up bit0 wake port, bit1 singles
// - Wakeup bit one enables wake pins 1-3
// - Wakeup bit zero enables logic port pins
// - Entry with enabled pin low returns immediately
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "odp_map.svh"
module odp_port_top #(
    parameter int PORT_W = 4  // Width of the four-bit ports
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Wake-capable port (pin 0 shares interrupt, pin 1 timer output)
    input  wire logic [3:0]  wake_port_in,
    output logic      [3:0]  wake_port_out,
    output logic      [3:0]  wake_port_oe,
    output logic      [3:0]  wake_port_pullup_en,
    // Logic-operation port
    input  wire logic [3:0]  logic_port_in,
    output logic      [3:0]  logic_port_out,
    output logic      [3:0]  logic_port_oe,
    // Individual-bit port (bits 2 and 3 share the single-bit ports)
    input  wire logic [3:0]  indiv_port_in,
    output logic      [3:0]  indiv_port_out,
    output logic      [3:0]  indiv_port_oe,
    output logic      [1:0]  single_pullup_en,
    // Two-bit open-drain port
    input  wire logic [1:0]  two_bit_port_in,
    output logic      [1:0]  two_bit_port_out,
    output logic      [1:0]  two_bit_port_oe,
    // Timer, interrupt and power
    input  wire logic        timer_underflow,
    output logic             ext_int_req,
    output logic             backup_active,
    output logic             irq
);
    // Elaboration check: the pin map is fixed at four bits
    if (PORT_W != 4) begin : g_chk
        $error("odp_port_top: PORT_W must be 4");
    end

    // Software-visible state, then the internal timer toggle and interrupt pin history
    logic [3:0]  wake_latch_reg;    // Wake port output latches
    logic [3:0]  logic_latch_reg;   // Logic port output latches
    logic [3:0]  indiv_latch_reg;   // Individual-bit latches
    logic [1:0]  two_bit_latch_reg; // Two-bit port latches
    logic [1:0]  single_latch_reg;  // Single-bit port latches, {k, c}
    logic [1:0]  pull_up_control_reg;
    logic [3:0]  key_wakeup_control_reg;
    logic [3:0]  altsel_reg;        // Alternate function selects
    logic [3:0]  acc_reg;           // Accumulator operand
    odp_pkg::odp_lop_e lop_reg;     // Selected logic operation
    logic [2:0]  irq_sts_reg;       // Sticky event bits
    logic [2:0]  irq_msk_reg;       // Event mask
    odp_pkg::odp_pwr_e pwr_reg;     // Run or back-up
    logic        tout_reg;          // Timer output divided by two
    logic        int_pin_reg;       // Previous interrupt pin level

    // Bus decode
    logic        setup_phase;       // Setup cycle of a transfer
    logic        wr_en;             // Write takes effect at this edge
    logic        rd_done;           // Read completes at this edge
    logic [31:0] rd_data;           // Read mux result
    logic        rd_err;            // Unmapped address
    logic [3:0]  lop_result;        // Logic operation result
    logic [2:0]  irq_clr_reg;       // Status bits returned by the read
    logic [2:0]  irq_set;           // Events this cycle
    logic        enter_backup;      // Back-up entry command
    logic        wake;              // Return condition

    // Wake detector, shared signals through the interface
    odp_wake_if wif ();
    assign wif.in_backup = (pwr_reg == odp_pkg::ODP_BACKUP);
    assign wif.wake_pin  = wake_port_in;
    assign wif.logic_pin = logic_port_in;
    assign wif.kwake     = key_wakeup_control_reg;
    assign wif.int_sel   = altsel_reg[`ODP_ALT_INT];
    assign wake          = wif.wake;
    odp_wake_detect u_wake (
        .wif (wif)
    );

    // Logic operation between accumulator and the port pins
    function automatic logic [3:0] do_lop(input odp_pkg::odp_lop_e op, input logic [3:0] a,
                                          input logic [3:0] b);
        case (op)
            odp_pkg::ODP_LOP_AND:  do_lop = a & b;
            odp_pkg::ODP_LOP_OR:   do_lop = a | b;
            odp_pkg::ODP_LOP_XOR:  do_lop = a ^ b;
            default:               do_lop = b;
        endcase
    endfunction

    // Zero-extend a narrow field into a bus word
    function automatic logic [31:0] zx(input logic [15:0] v);
        zx = {16'h0000, v};
    endfunction

    assign setup_phase  = psel && !penable;
    assign wr_en        = psel && penable && pready && pwrite;
    assign rd_done      = psel && penable && pready && !pwrite;
    assign lop_result   = do_lop(lop_reg, acc_reg, logic_port_in);
    assign enter_backup = wr_en && (paddr == `ODP_OFS_BACKUP) && pwdata[0];

    // Read mux; pin reads show the pin level, so a latch left at zero reads low
    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        case (paddr)
            `ODP_OFS_WAKE:   rd_data = zx({12'h000, wake_latch_reg});
            `ODP_OFS_LOGIC:  rd_data = zx({12'h000, logic_latch_reg});
            `ODP_OFS_INDIV:  rd_data = zx({12'h000, indiv_latch_reg});
            `ODP_OFS_TWOBIT: rd_data = zx({14'h0000, two_bit_latch_reg});
            `ODP_OFS_SINGLE: rd_data = zx({14'h0000, single_latch_reg});
            `ODP_OFS_PULLUP: rd_data = zx({14'h0000, pull_up_control_reg});
            `ODP_OFS_KWAKE:  rd_data = zx({12'h000, key_wakeup_control_reg});
            `ODP_OFS_ALTSEL: rd_data = zx({12'h000, altsel_reg});
            // Pin levels, still readable while alternates are selected
            `ODP_OFS_PINS:   rd_data = zx({2'h0, two_bit_port_in, indiv_port_in, logic_port_in, wake_port_in});
            `ODP_OFS_LOPREG: rd_data = zx({6'h00, lop_reg, acc_reg, lop_result});
            `ODP_OFS_BACKUP: rd_data = zx({15'h0000, pwr_reg == odp_pkg::ODP_BACKUP});
            `ODP_OFS_IRQSTS: rd_data = zx({13'h0000, irq_sts_reg});
            `ODP_OFS_IRQMSK: rd_data = zx({13'h0000, irq_msk_reg});
            default:         rd_err  = 1'b1;
        endcase
    end

    // APB answer: one wait-free access cycle after each setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready      <= 1'b0;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
            irq_clr_reg <= `ODP_RST_IRQ;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && rd_err;
            // Capture at setup; status clears only the bits actually returned
            if (setup_phase) begin
                prdata      <= pwrite ? 32'h0000_0000 : rd_data;
                irq_clr_reg <= (!pwrite && paddr == `ODP_OFS_IRQSTS) ? irq_sts_reg : `ODP_RST_IRQ;
            end
        end
    end

    // Port latches; reset loads ones, software writes one before input use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_latch_reg    <= `ODP_RST_LATCH4;
            logic_latch_reg   <= `ODP_RST_LATCH4;
            indiv_latch_reg   <= `ODP_RST_LATCH4;
            two_bit_latch_reg <= `ODP_RST_LATCH2;
            single_latch_reg  <= `ODP_RST_LATCH2;
        end else if (wr_en) begin
            case (paddr)
                `ODP_OFS_WAKE:   wake_latch_reg    <= pwdata[3:0];
                `ODP_OFS_LOGIC:  logic_latch_reg   <= pwdata[3:0];
                `ODP_OFS_INDIV:  indiv_latch_reg   <= pwdata[3:0];
                `ODP_OFS_TWOBIT: two_bit_latch_reg <= pwdata[1:0];
                `ODP_OFS_SINGLE: single_latch_reg  <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_control_reg    <= `ODP_RST_PULLUP;
            key_wakeup_control_reg <= `ODP_RST_KWAKE;
            altsel_reg             <= `ODP_RST_ALTSEL;
            acc_reg                <= 4'h0;
            lop_reg                <= odp_pkg::ODP_LOP_AND;
            irq_msk_reg            <= `ODP_RST_IRQ;
        end else if (wr_en) begin
            case (paddr)
                `ODP_OFS_PULLUP: pull_up_control_reg    <= pwdata[1:0];
                `ODP_OFS_KWAKE:  key_wakeup_control_reg <= pwdata[3:0];
                `ODP_OFS_ALTSEL: altsel_reg             <= pwdata[3:0];
                `ODP_OFS_LOPREG: begin
                    acc_reg <= pwdata[3:0];
                    lop_reg <= odp_pkg::odp_lop_e'(pwdata[5:4]);
                end
                `ODP_OFS_IRQMSK: irq_msk_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Power state; entry while an enabled key or interrupt pin is low returns on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg <= odp_pkg::ODP_RUN;
        end else begin
            case (pwr_reg)
                odp_pkg::ODP_RUN:    if (enter_backup) pwr_reg <= odp_pkg::ODP_BACKUP;
                odp_pkg::ODP_BACKUP: if (wake) pwr_reg <= odp_pkg::ODP_RUN;
                default:             pwr_reg <= odp_pkg::ODP_RUN;
            endcase
        end
    end

    // Timer toggle and interrupt pin edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_reg    <= 1'b1;
            int_pin_reg <= 1'b1;
            ext_int_req <= 1'b0;
        end else begin
            if (timer_underflow) begin
                tout_reg <= !tout_reg;
            end
            int_pin_reg <= wake_port_in[0];
            // Falling edge requests the external interrupt
            ext_int_req <= altsel_reg[`ODP_ALT_INT] && int_pin_reg && !wake_port_in[0];
        end
    end

    // Sticky events; a set in the clearing cycle survives
    assign irq_set = {timer_underflow && altsel_reg[`ODP_ALT_TOUT],
                      (pwr_reg == odp_pkg::ODP_BACKUP) && wake,
                      altsel_reg[`ODP_ALT_INT] && int_pin_reg && !wake_port_in[0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_reg <= `ODP_RST_IRQ;
            irq         <= 1'b0;
        end else begin
            irq_sts_reg <= (irq_sts_reg & ~(rd_done ? irq_clr_reg : `ODP_RST_IRQ)) | irq_set;
            irq         <= |(irq_sts_reg & irq_msk_reg);
        end
    end

    // Open-drain drivers: output always low, enable pulls the pin down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_port_out    <= 4'h0;
            logic_port_out   <= 4'h0;
            indiv_port_out   <= 4'h0;
            two_bit_port_out <= 2'h0;
            wake_port_oe     <= 4'h0;
            logic_port_oe    <= 4'h0;
            indiv_port_oe    <= 4'h0;
            two_bit_port_oe  <= 2'h0;
        end else begin
            wake_port_out    <= 4'h0;
            logic_port_out   <= 4'h0;
            indiv_port_out   <= 4'h0;
            two_bit_port_out <= 2'h0;
            wake_port_oe[0]  <= !wake_latch_reg[0];
            // Timer output replaces latch 1 when selected
            wake_port_oe[1]  <= altsel_reg[`ODP_ALT_TOUT] ? !tout_reg : !wake_latch_reg[1];
            wake_port_oe[3:2] <= ~wake_latch_reg[3:2];
            logic_port_oe    <= ~logic_latch_reg;
            two_bit_port_oe  <= ~two_bit_latch_reg;
            indiv_port_oe[1:0] <= ~indiv_latch_reg[1:0];
            // Shared pins: either owner may pull low (wired AND)
            indiv_port_oe[2] <= !indiv_latch_reg[2] || (altsel_reg[`ODP_ALT_C] && !single_latch_reg[0]);
            indiv_port_oe[3] <= !indiv_latch_reg[3] || (altsel_reg[`ODP_ALT_K] && !single_latch_reg[1]);
        end
    end

    // Pull-up enables and power status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_port_pullup_en <= 4'h0;
            single_pullup_en    <= 2'h0;
            backup_active       <= 1'b0;
        end else begin
            wake_port_pullup_en <= {4{pull_up_control_reg[`ODP_PU_WAKE]}};
            single_pullup_en    <= {2{pull_up_control_reg[`ODP_PU_SINGLE]}};
            backup_active       <= (pwr_reg == odp_pkg::ODP_BACKUP);
        end
    end

    // Checks on the block's own behaviour
    sequence s_enter;
        enter_backup && (pwr_reg == odp_pkg::ODP_RUN);
    endsequence
    sequence s_back_low;
        (pwr_reg == odp_pkg::ODP_BACKUP) && key_wakeup_control_reg[`ODP_KW_LOGIC] && (logic_port_in != 4'hF);
    endsequence
    // Any enabled key source held low while in back-up
    sequence s_back_key;
        (pwr_reg == odp_pkg::ODP_BACKUP) && ((key_wakeup_control_reg[`ODP_KW_LOGIC] && logic_port_in != 4'hF) ||
            (key_wakeup_control_reg[`ODP_KW_WAKE] && wake_port_in[3:1] != 3'h7));
    endsequence
    property p_od_logic;
        @(posedge pclk) disable iff (!presetn) logic_port_oe == ~$past(logic_latch_reg);
    endproperty
    a_od_logic: assert property (p_od_logic) else $error("logic port drive wrong");
    property p_pull_wake;
        @(posedge pclk) disable iff (!presetn) wr_en && paddr == `ODP_OFS_PULLUP |=> ##1
            wake_port_pullup_en == {4{$past(pwdata[0], 2)}};
    endproperty
    a_pull_wake: assert property (p_pull_wake) else $error("wake pull-up wrong");
    property p_pull_single;
        @(posedge pclk) disable iff (!presetn) single_pullup_en == {2{$past(pull_up_control_reg[1])}};
    endproperty
    a_pull_single: assert property (p_pull_single) else $error("single pull-up wrong");
    property p_tout;
        @(posedge pclk) disable iff (!presetn) altsel_reg[`ODP_ALT_TOUT] && timer_underflow
            && $stable(altsel_reg) |=> ##1 wake_port_oe[1] == !tout_reg && wake_port_oe[1] != $past(wake_port_oe[1]);
    endproperty
    a_tout: assert property (p_tout) else $error("timer output did not toggle");
    property p_wake_logic;
        @(posedge pclk) disable iff (!presetn) s_back_low |=> pwr_reg == odp_pkg::ODP_RUN;
    endproperty
    a_wake_logic: assert property (p_wake_logic) else $error("logic port wake missed");
    property p_wake_g;
        @(posedge pclk) disable iff (!presetn) (pwr_reg == odp_pkg::ODP_BACKUP) &&
            key_wakeup_control_reg[`ODP_KW_WAKE] && wake_port_in[3:1] != 3'h7 |=> ##1 !backup_active[*2];
    endproperty
    a_wake_g: assert property (p_wake_g) else $error("wake port wake missed");
    property p_no_wake;
        @(posedge pclk) disable iff (!presetn) (pwr_reg == odp_pkg::ODP_BACKUP) && !altsel_reg[`ODP_ALT_INT] &&
            !key_wakeup_control_reg[`ODP_KW_WAKE] &&
            !(key_wakeup_control_reg[`ODP_KW_LOGIC] && logic_port_in != 4'hF) |=> pwr_reg == odp_pkg::ODP_BACKUP;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake while disabled");
    property p_int;
        @(posedge pclk) disable iff (!presetn) altsel_reg[`ODP_ALT_INT] && $fell(wake_port_in[0])
            |=> ext_int_req ##1 !ext_int_req;
    endproperty
    a_int: assert property (p_int) else $error("external interrupt missed");
    property p_immediate;
        @(posedge pclk) disable iff (!presetn) s_enter ##1 s_back_key |-> ##[1:2] backup_active == 1'b0;
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate return missed");
    property p_shared_c;
        @(posedge pclk) disable iff (!presetn) altsel_reg[`ODP_ALT_C] && !indiv_latch_reg[2] |=> indiv_port_oe[2];
    endproperty
    a_shared_c: assert property (p_shared_c) else $error("shared bit drive lost");
endmodule

//--- hw/odp_wake_detect.sv
// Key-on wakeup return condition detector
`timescale 1ns/100ps
`include "odp_map.svh"
module odp_wake_detect (
    odp_wake_if.det wif
);
    logic logic_hit;  // Enabled logic-operation pin held low
    logic wake_hit;   // Enabled wake port pin 1..3 held low
    logic int_hit;    // Interrupt input held low
    // Low level on an enabled pin is the return condition; level, not edge,
    // so a pin already low at entry wakes at once
    always_comb begin
        logic_hit = wif.kwake[`ODP_KW_LOGIC] && (wif.logic_pin != 4'hF);
        wake_hit  = wif.kwake[`ODP_KW_WAKE] && (wif.wake_pin[3:1] != 3'h7);
        int_hit   = wif.int_sel && !wif.wake_pin[0];
        wif.wake  = wif.in_backup && (logic_hit || wake_hit || int_hit);
    end
endmodule

//--- pkg/odp_map.svh
// Register offsets, reset values and widths of the open-drain port block
`ifndef ODP_MAP_SVH
`define ODP_MAP_SVH
`define ODP_ADDR_W      8
`define ODP_OFS_WAKE    8'h00
`define ODP_OFS_LOGIC   8'h04
`define ODP_OFS_INDIV   8'h08
`define ODP_OFS_TWOBIT  8'h0C
`define ODP_OFS_PULLUP  8'h10
`define ODP_OFS_KWAKE   8'h14
`define ODP_OFS_ALTSEL  8'h18
`define ODP_OFS_PINS    8'h1C
`define ODP_OFS_LOPREG  8'h20
`define ODP_OFS_BACKUP  8'h24
`define ODP_OFS_IRQSTS  8'h28
`define ODP_OFS_IRQMSK  8'h2C
`define ODP_OFS_SINGLE  8'h30
`define ODP_RST_LATCH4  4'hF
`define ODP_RST_LATCH2  2'h3
`define ODP_RST_PULLUP  2'h0
`define ODP_RST_KWAKE   4'h0
`define ODP_RST_ALTSEL  4'h0
`define ODP_RST_IRQ     3'h0
`define ODP_PU_WAKE     0
`define ODP_PU_SINGLE   1
`define ODP_KW_LOGIC    0
`define ODP_KW_WAKE     1
`define ODP_ALT_INT     0
`define ODP_ALT_TOUT    1
`define ODP_ALT_C       2
`define ODP_ALT_K       3
`define ODP_IRQ_EXT     0
`define ODP_IRQ_WAKE    1
`define ODP_IRQ_TMR     2
`endif

//--- pkg/odp_pkg.sv
// Types shared by the open-drain port block
package odp_pkg;
    // Power state of the port controller
    typedef enum logic {ODP_RUN, ODP_BACKUP} odp_pwr_e;
    // Logic operation applied between accumulator and the logic-operation port
    typedef enum logic [1:0] {ODP_LOP_AND, ODP_LOP_OR, ODP_LOP_XOR, ODP_LOP_PASS} odp_lop_e;
endpackage

//--- pkg/odp_wake_if.sv
// Interface carrying wake sensing signals between controller and detector
`timescale 1ns/100ps
interface odp_wake_if;
    logic       in_backup;   // Controller is in RAM back-up
    logic [3:0] wake_pin;    // Wake-capable port pin levels
    logic [3:0] logic_pin;   // Logic-operation port pin levels
    logic [3:0] kwake;       // Key-on wakeup control
    logic       int_sel;     // Interrupt input function selected
    logic       wake;        // Return condition seen
    modport ctrl (output in_backup, wake_pin, logic_pin, kwake, int_sel, input wake);
    modport det  (input in_backup, wake_pin, logic_pin, kwake, int_sel, output wake);
endinterface
